// file: hb_pwm_pkg.sv
// Purpose: Shared constants and types for the six-input half-bridge control
// Assumes: 125 MHz core clock, classic Wishbone register access
// Notes:   Offsets are byte addresses of 32-bit words
package hb_pwm_pkg;
    // ==========================================================
    // Geometry and clock
    localparam int NUM_HB        = 3;
    localparam int CLK_PERIOD_NS = 8;
    localparam int DLY_W         = 8;
    localparam int CNT_W         = 4;
    localparam int TMR_W         = 12;
    localparam int CUR_W         = 6;

    // ==========================================================
    // Timing (ns as set, cycles derived; least times round up)
    localparam int ACT_CCP_NS    = 1000;
    localparam int FW_CCP_NS     = 2000;
    localparam int FW_TMO_NS     = 4000;
    localparam int ACT_CCP_CYC   = (ACT_CCP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FW_CCP_CYC    = (FW_CCP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FW_TMO_CYC    = (FW_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Delay regulation
    localparam logic [CNT_W-1:0] REG_CNT_MAX   = 4'hF;
    localparam logic [CNT_W-1:0] REG_CNT_THR   = 4'h8;
    localparam logic [1:0]       SIGN_CHG_THR  = 2'h3;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_MODE   = 8'h04;
    localparam logic [7:0] ADDR_TON    = 8'h08;
    localparam logic [7:0] ADDR_TOFF   = 8'h0C;
    localparam logic [7:0] ADDR_CURR   = 8'h10;
    localparam logic [7:0] ADDR_STAT   = 8'h14;
    localparam logic [7:0] ADDR_EFF1   = 8'h18;
    localparam logic [7:0] ADDR_EFF2   = 8'h1C;
    localparam logic [7:0] ADDR_EFF3   = 8'h20;

    // CTRL fields
    localparam int CTRL_INCNT_BIT = 0;
    localparam int CTRL_DET_BIT   = 1;
    localparam int CTRL_PCD_BIT   = 2;
    localparam int CTRL_AGC_LSB   = 4;
    localparam int CTRL_PEN_LSB   = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_MSK = 32'h0000_0737;
    localparam logic [31:0] MODE_RST = 32'h0000_0000;
    localparam logic [31:0] MODE_MSK = 32'h0000_003F;
    localparam logic [31:0] DLY_RST  = 32'h0000_0000;
    localparam logic [31:0] DLY_MSK  = 32'h00FF_FFFF;
    localparam logic [31:0] CURR_RST = 32'h0000_0000;
    localparam logic [31:0] CURR_MSK = 32'h003F_3F3F;

    // STAT fields
    localparam int STAT_REG_LSB = 0;
    localparam int STAT_ACT_LSB = 4;
    localparam int STAT_HS_LSB  = 8;
    localparam int STAT_LS_LSB  = 12;

    // ==========================================================
    // Mode codes
    localparam logic [1:0] MODE_PASSIVE = 2'b00;
    localparam logic [1:0] MODE_LS_ACT  = 2'b01;
    localparam logic [1:0] MODE_HS_ACT  = 2'b10;
    localparam logic [1:0] MODE_HOLD    = 2'b11;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_HS  = 2'b01,
        ST_GAP = 2'b11,
        ST_LS  = 2'b10
    } hb_state_e;

    typedef struct packed {
        logic             strobe;
        logic             unmeasurable;
        logic [DLY_W-1:0] turn_on;
        logic [DLY_W-1:0] turn_off;
    } meas_s;
endpackage

// file: hb_pwm_ctrl.sv
// Purpose: Six-input PWM control of three half-bridges with delay regulation
// Assumes: Measurement strobes come from same-clock logic; PWM and detect pins are async
// Notes:   Three-input operation is not covered; bridges stay off when it is selected
//
// Behaviour
// [R1] Six-input mode: each switch from own input
// [R2] Mode 00 passive off, default
// [R3] Mode 11 actively holds both off
// [R4] Mode 01 without detection: low side active
// [R5] Mode 10 without detection: high side active
// [R6] Detection enabled: sensed side decides active switch
// [R7] Mode 01 input pair decode table
// [R8] Mode 10 input pair decode table
// [R9] Inputs paired per bridge, same decode
// [R10] Turn-on: freewheel off first, then active
// [R11] Late edge: hard-off discharge, immediate turn-on
// [R12] Early active edge blocked until freewheel time
// [R13] Turn-off: active off first, then freewheel
// [R14] Early freewheel edge blocked until active time
// [R15] Regulation flag per bridge, adaptive settings only
// [R16] Delay counters up on match, else down
// [R17] Regulated when both counters reach eight
// [R18] Regulated after three consecutive error sign changes
// [R19] Six-bit gate current code per driver
// [R20] Unmeasurable cycle reports zero delays
// [R21] Counters saturate; flag updated per cycle
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module hb_pwm_ctrl
    import hb_pwm_pkg::*;
#(
    parameter int ACT_CCP = ACT_CCP_CYC,
    parameter int FW_CCP  = FW_CCP_CYC,
    parameter int FW_TMO  = FW_TMO_CYC
) (
    // Clock and reset
    input  wire logic                    CORE_CLK_I,
    input  wire logic                    RST_I,
    // Wishbone slave
    input  wire logic                    CYC_I,
    input  wire logic                    STB_I,
    input  wire logic                    WE_I,
    input  wire logic [7:0]              ADR_I,
    input  wire logic [3:0]              SEL_I,
    input  wire logic [31:0]             DAT_I,
    output logic      [31:0]             DAT_O,
    output logic                         ACK_O,
    // Drive inputs, pin order one to six
    input  wire logic [2*NUM_HB-1:0]     DRIVE_INPUT_I,
    // Sensed active side per bridge, high = high side
    input  wire logic [NUM_HB-1:0]       ACTIVE_SENSE_I,
    // Switching time measurements
    input  wire meas_s [NUM_HB-1:0]      MEAS_I,
    // Gate driver controls
    output logic      [NUM_HB-1:0]       HIGH_SIDE_SWITCH_O,
    output logic      [NUM_HB-1:0]       LOW_SIDE_SWITCH_O,
    output logic      [NUM_HB-1:0]       ACTIVE_HOLD_OFF_O,
    output logic      [NUM_HB-1:0]       HARD_OFF_CURRENT_O,
    output logic      [NUM_HB*CUR_W-1:0] GATE_CURRENT_O,
    output logic      [NUM_HB-1:0]       DELAY_REGULATION_FLAG_O
);

    // ==========================================================
    // Register file
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] mode_r, mode_nxt;
    logic [31:0] ton_r, ton_nxt;
    logic [31:0] toff_r, toff_nxt;
    logic [31:0] curr_r, curr_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic        ack_r, ack_nxt;

    logic [NUM_HB-1:0] hs_r, ls_r, hold_r, hard_r, flag_r, act_hs;
    logic [2*DLY_W-1:0] eff_r [NUM_HB];

    logic        input_count_select;
    logic        active_freewheel_detect_enable;
    logic [1:0]  gate_control_select;
    logic [NUM_HB-1:0] half_bridge_pulse_enable;
    logic        adaptive;

    assign input_count_select             = ctrl_r[CTRL_INCNT_BIT];
    assign active_freewheel_detect_enable = ctrl_r[CTRL_DET_BIT];
    assign gate_control_select            = ctrl_r[CTRL_AGC_LSB+1:CTRL_AGC_LSB];
    assign half_bridge_pulse_enable       = ctrl_r[CTRL_PEN_LSB+NUM_HB-1:CTRL_PEN_LSB];
    assign adaptive                       = gate_control_select[1]; // [R15]

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel, input logic [31:0] msk);
        logic [31:0] res;
        res = old;

        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b+:8] = wd[8*b+:8];
            end
        end
        return res & msk;
    endfunction

    logic req;
    assign req = CYC_I && STB_I && !ack_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        mode_nxt = mode_r;
        ton_nxt  = ton_r;
        toff_nxt = toff_r;
        curr_nxt = curr_r;
        ack_nxt  = req;
        dat_nxt  = dat_r;

        if (req && WE_I) begin
            unique case (ADR_I)
                ADDR_CTRL: ctrl_nxt = merge(ctrl_r, DAT_I, SEL_I, CTRL_MSK);
                ADDR_MODE: mode_nxt = merge(mode_r, DAT_I, SEL_I, MODE_MSK);
                ADDR_TON:  ton_nxt  = merge(ton_r, DAT_I, SEL_I, DLY_MSK);
                ADDR_TOFF: toff_nxt = merge(toff_r, DAT_I, SEL_I, DLY_MSK);
                ADDR_CURR: curr_nxt = merge(curr_r, DAT_I, SEL_I, CURR_MSK); // [R19]
                default: ;
            endcase
        end

        if (req && !WE_I) begin
            unique case (ADR_I)
                ADDR_CTRL: dat_nxt = ctrl_r;
                ADDR_MODE: dat_nxt = mode_r;
                ADDR_TON:  dat_nxt = ton_r;
                ADDR_TOFF: dat_nxt = toff_r;
                ADDR_CURR: dat_nxt = curr_r;
                ADDR_STAT: begin
                    dat_nxt = 32'h0000_0000;
                    dat_nxt[STAT_REG_LSB+:NUM_HB] = flag_r;
                    dat_nxt[STAT_ACT_LSB+:NUM_HB] = act_hs;
                    dat_nxt[STAT_HS_LSB+:NUM_HB]  = hs_r;
                    dat_nxt[STAT_LS_LSB+:NUM_HB]  = ls_r;
                end
                ADDR_EFF1: dat_nxt = {16'h0000, eff_r[0]};
                ADDR_EFF2: dat_nxt = {16'h0000, eff_r[1]};
                ADDR_EFF3: dat_nxt = {16'h0000, eff_r[2]};
                default:   dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_r <= CTRL_RST;
            mode_r <= MODE_RST; // [R2]
            ton_r  <= DLY_RST;
            toff_r <= DLY_RST;
            curr_r <= CURR_RST;

            dat_r  <= 32'h0000_0000;
            ack_r  <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            ton_r  <= ton_nxt;
            toff_r <= toff_nxt;
            curr_r <= curr_nxt;

            dat_r  <= dat_nxt;
            ack_r  <= ack_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign DAT_O                   = dat_r;
    assign ACK_O                   = ack_r;
    assign GATE_CURRENT_O          = {curr_r[21:16], curr_r[13:8], curr_r[5:0]}; // [R19]
    assign HIGH_SIDE_SWITCH_O      = hs_r;
    assign LOW_SIDE_SWITCH_O       = ls_r;
    assign ACTIVE_HOLD_OFF_O       = hold_r;
    assign HARD_OFF_CURRENT_O      = hard_r;
    assign DELAY_REGULATION_FLAG_O = flag_r;

    // ==========================================================
    // Pin synchronisers
    logic [2*NUM_HB-1:0] pin_meta_r, pin_sync_r;
    logic [NUM_HB-1:0]   sense_meta_r, sense_sync_r;

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pin_meta_r   <= '0;
            pin_sync_r   <= '0;

            sense_meta_r <= '0;
            sense_sync_r <= '0;
        end else begin
            pin_meta_r   <= DRIVE_INPUT_I;
            pin_sync_r   <= pin_meta_r;

            sense_meta_r <= ACTIVE_SENSE_I;
            sense_sync_r <= sense_meta_r;
        end
    end

    // ==========================================================
    // Per half-bridge control
    localparam logic [TMR_W-1:0] T_ACT = TMR_W'(ACT_CCP);
    localparam logic [TMR_W-1:0] T_FW  = TMR_W'(FW_CCP);
    localparam logic [TMR_W-1:0] T_TMO = TMR_W'(FW_TMO);

    for (genvar i = 0; i < NUM_HB; i++) begin : g_hb
        logic [1:0] mode_sel;
        logic       in_a, in_b, hs_req, ls_req, run;
        hb_state_e  st_r, st_nxt;
        logic [TMR_W-1:0] tmr_r, tmr_nxt;
        logic       prev_hs_r, prev_hs_nxt, hard_nxt;

        assign mode_sel = mode_r[2*i+1:2*i];
        assign in_a     = pin_sync_r[2*i];   // [R9]
        assign in_b     = pin_sync_r[2*i+1]; // [R9]

        assign run      = input_count_select && half_bridge_pulse_enable[i]
                          && (mode_sel == MODE_LS_ACT || mode_sel == MODE_HS_ACT); // [R1] [R2] [R3]
        assign hs_req   = (mode_sel == MODE_LS_ACT) ? (!in_a && in_b) : (in_a && !in_b); // [R7] [R8]
        assign ls_req   = (mode_sel == MODE_LS_ACT) ? (in_a && !in_b) : (!in_a && in_b); // [R7] [R8]
        assign act_hs[i] = active_freewheel_detect_enable ? sense_sync_r[i]   // [R6]
                                                          : (mode_sel == MODE_HS_ACT); // [R4] [R5]

        always_comb begin
            st_nxt      = st_r;
            tmr_nxt     = tmr_r;
            prev_hs_nxt = prev_hs_r;
            hard_nxt    = 1'b0;

            if (!run) begin
                st_nxt  = ST_OFF;
                tmr_nxt = '0;
            end else begin
                unique case (st_r)
                    ST_OFF: begin
                        if (hs_req) begin
                            st_nxt = ST_HS;
                        end else if (ls_req) begin
                            st_nxt = ST_LS;
                        end
                    end
                    ST_HS: begin
                        if (!hs_req) begin
                            st_nxt      = ST_GAP; // [R13] [R10]
                            tmr_nxt     = '0;
                            prev_hs_nxt = 1'b1;
                        end
                    end
                    ST_LS: begin
                        if (!ls_req) begin
                            st_nxt      = ST_GAP; // [R10] [R13]
                            tmr_nxt     = '0;
                            prev_hs_nxt = 1'b0;
                        end
                    end
                    ST_GAP: begin
                        if (tmr_r != T_TMO) begin
                            tmr_nxt = tmr_r + 1'b1;
                        end

                        // Active side waits for the freewheel window, freewheel side for the active one
                        if (hs_req && tmr_r >= (act_hs[i] ? T_FW : T_ACT)) begin // [R12] [R14]
                            st_nxt   = ST_HS;
                            hard_nxt = act_hs[i] && !prev_hs_r && (tmr_r < T_TMO); // [R11]
                        end else if (ls_req && tmr_r >= (act_hs[i] ? T_ACT : T_FW)) begin // [R14] [R12]
                            st_nxt   = ST_LS;
                            hard_nxt = !act_hs[i] && prev_hs_r && (tmr_r < T_TMO); // [R11]
                        end else if (!hs_req && !ls_req && tmr_r == T_TMO) begin
                            st_nxt = ST_OFF;
                        end
                    end
                endcase
            end
        end

        always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
            if (RST_I) begin
                st_r      <= ST_OFF;
                tmr_r     <= '0;
                prev_hs_r <= 1'b0;
                hs_r[i]   <= 1'b0;
                ls_r[i]   <= 1'b0;
                hold_r[i] <= 1'b0;
                hard_r[i] <= 1'b0;
            end else begin
                st_r      <= st_nxt;
                tmr_r     <= tmr_nxt;
                prev_hs_r <= prev_hs_nxt;
                hs_r[i]   <= (st_nxt == ST_HS);
                ls_r[i]   <= (st_nxt == ST_LS);

                hold_r[i] <= (mode_sel == MODE_HOLD); // [R3]
                hard_r[i] <= hard_nxt;
            end
        end

        // ==========================================================
        // Delay regulation
        logic [DLY_W-1:0] tgt_on, tgt_off, e_on, e_off;
        logic [CNT_W-1:0] con_r, con_nxt, coff_r, coff_nxt;
        logic [1:0]       son_r, son_nxt, soff_r, soff_nxt;
        logic [1:0]       lon_r, lon_nxt, loff_r, loff_nxt;
        logic             flag_nxt;
        logic [2*DLY_W-1:0] eff_nxt;

        assign tgt_on  = ton_r[DLY_W*i+:DLY_W];
        assign tgt_off = toff_r[DLY_W*i+:DLY_W];
        assign e_on    = MEAS_I[i].unmeasurable ? '0 : MEAS_I[i].turn_on;  // [R20]
        assign e_off   = MEAS_I[i].unmeasurable ? '0 : MEAS_I[i].turn_off; // [R20]

        function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c, input logic up);
            if (up) begin
                return (c == REG_CNT_MAX) ? c : c + 1'b1; // [R21]
            end
            return (c == '0) ? c : c - 1'b1;              // [R21]
        endfunction

        // Sign track: last = {valid, positive}; count of consecutive changes
        function automatic logic [3:0] sgn(input logic [1:0] last, input logic [1:0] n,
                                           input logic [DLY_W-1:0] e, input logic [DLY_W-1:0] t);
            logic [1:0] cur;
            cur = {e != t, e > t};

            if (!cur[1]) begin
                return {last, n};
            end
            if (last[1] && last[0] != cur[0]) begin
                return {cur, (n == SIGN_CHG_THR) ? n : n + 1'b1}; // [R18]
            end
            return {cur, 2'b00};
        endfunction

        always_comb begin
            con_nxt  = con_r;
            coff_nxt = coff_r;
            son_nxt  = son_r;
            soff_nxt = soff_r;
            lon_nxt  = lon_r;
            loff_nxt = loff_r;
            eff_nxt  = eff_r[i];
            flag_nxt = flag_r[i] && adaptive;

            if (MEAS_I[i].strobe) begin
                con_nxt  = step(con_r, e_on == tgt_on);    // [R16]
                coff_nxt = step(coff_r, e_off == tgt_off); // [R16]
                {lon_nxt, son_nxt}   = sgn(lon_r, son_r, e_on, tgt_on);
                {loff_nxt, soff_nxt} = sgn(loff_r, soff_r, e_off, tgt_off);
                eff_nxt  = {e_off, e_on}; // [R20]
                flag_nxt = adaptive && (((con_nxt >= REG_CNT_THR) && (coff_nxt >= REG_CNT_THR))    // [R17]
                           || ((son_nxt == SIGN_CHG_THR) && (soff_nxt == SIGN_CHG_THR))); // [R18] [R15] [R21]
            end
        end

        always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
            if (RST_I) begin
                con_r     <= '0;
                coff_r    <= '0;
                son_r     <= '0;
                soff_r    <= '0;
                lon_r     <= '0;
                loff_r    <= '0;

                eff_r[i]  <= '0;
                flag_r[i] <= 1'b0;
            end else begin
                con_r     <= con_nxt;
                coff_r    <= coff_nxt;
                son_r     <= son_nxt;
                soff_r    <= soff_nxt;
                lon_r     <= lon_nxt;
                loff_r    <= loff_nxt;

                eff_r[i]  <= eff_nxt;
                flag_r[i] <= flag_nxt;
            end
        end
    end

endmodule

// file: hb_pwm_ctrl_checker.sv
// Purpose: Port assertions for hb_pwm_ctrl
// Assumes: One clock, reset active high
// Notes:   Gap checks watch bridge 0
`timescale 1ns/10ps
module hb_pwm_ctrl_checker
    import hb_pwm_pkg::*;
#(
    parameter int ACT_CCP = ACT_CCP_CYC,
    parameter int FW_CCP  = FW_CCP_CYC,
    parameter int FW_TMO  = FW_TMO_CYC
) (
    // Clock, reset, bus
    input wire logic                    CORE_CLK_I,
    input wire logic                    RST_I,
    input wire logic                    CYC_I,
    input wire logic                    STB_I,
    input wire logic                    WE_I,
    input wire logic                    ACK_O,
    // Bridges
    input wire meas_s [NUM_HB-1:0]      MEAS_I,
    input wire logic [NUM_HB-1:0]       HIGH_SIDE_SWITCH_O,
    input wire logic [NUM_HB-1:0]       LOW_SIDE_SWITCH_O,
    input wire logic [NUM_HB-1:0]       ACTIVE_HOLD_OFF_O,
    input wire logic [NUM_HB-1:0]       HARD_OFF_CURRENT_O,
    input wire logic [NUM_HB*CUR_W-1:0] GATE_CURRENT_O,
    input wire logic [NUM_HB-1:0]       DELAY_REGULATION_FLAG_O
);
    // ==========
    // Assertions
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    a_ack_follow: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("access not acknowledged");
    a_ack_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("acknowledge too long");
    a_no_overlap: assert property ((HIGH_SIDE_SWITCH_O & LOW_SIDE_SWITCH_O) == '0)
        else $error("both switches on");
    a_hold_off: assert property ((ACTIVE_HOLD_OFF_O & (HIGH_SIDE_SWITCH_O | LOW_SIDE_SWITCH_O)) == '0)
        else $error("switch on while held off");
    a_curr_write: assert property ($changed(GATE_CURRENT_O) |-> ACK_O && WE_I)
        else $error("gate current changed without write");
    a_hard_off: assert property (HARD_OFF_CURRENT_O[0] |-> $rose(HIGH_SIDE_SWITCH_O[0]) || $rose(LOW_SIDE_SWITCH_O[0]))
        else $error("hard off pulse without turn-on");
    a_hs_gap: assert property ($fell(HIGH_SIDE_SWITCH_O[0]) |-> !LOW_SIDE_SWITCH_O[0] [*2])
        else $error("low side on too soon");
    a_ls_gap: assert property ($fell(LOW_SIDE_SWITCH_O[0]) |-> !HIGH_SIDE_SWITCH_O[0] [*2])
        else $error("high side on too soon");
    a_flag_cause: assert property ($rose(DELAY_REGULATION_FLAG_O[0]) |-> $past(MEAS_I[0].strobe))
        else $error("flag set without strobe");
    c_hard_off: cover property (HARD_OFF_CURRENT_O[0]);
    c_flag_set: cover property ($rose(DELAY_REGULATION_FLAG_O[0]));
    c_ls_on: cover property ($rose(LOW_SIDE_SWITCH_O[0]));
endmodule

// file: hb_host_model.sv
// Purpose: Host driving the six drive inputs
// Assumes: Pattern request from the bench
// Notes:   A new pattern reaches the pins lag_i + 1 cycles after the model takes it in
`timescale 1ns/10ps
module hb_host_model (
    // Clock and request
    input  wire logic       clk_i,
    input  wire logic [5:0] pat_i,
    input  wire logic [3:0] lag_i,
    // Drive pins
    output logic      [5:0] pins_o
);
    logic [5:0] want_r = 6'h00;
    logic [3:0] cnt_r  = 4'h0;
    initial pins_o = 6'h00;
    always @(posedge clk_i) begin
        if (pat_i != want_r) begin
            want_r <= pat_i;
            cnt_r <= lag_i;
        end else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
        else
            pins_o <= want_r;
    end
endmodule

// file: hb_pwm_ctrl_tb.sv
// Purpose: Self-checking bench for hb_pwm_ctrl
// Assumes: Protection windows shortened to 2/4/8 cycles
// Notes:   Reads and bridge snapshots checked from queues
`timescale 1ns/10ps
module hb_pwm_ctrl_tb
    import hb_pwm_pkg::*;
;
    // ==========
    // Signals
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we  = 1'b0;
    logic        smp = 1'b0;
    logic        ack;
    logic [7:0]  adr = 8'h00;
    logic [7:0]  t;
    logic [3:0]  lag = 4'h0;
    logic [5:0]  pat = 6'h00;
    logic [5:0]  pins;
    logic [2:0]  sense = 3'h0;
    logic [2:0]  hs, ls, hold, hard, flag;
    logic [17:0] gcur;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, d, ctrl, mode;
    logic [11:0] e;
    meas_s [2:0] meas = '0;
    logic [31:0] rd_q[$];
    logic [11:0] sw_q[$];
    int          n_errors = 0;
    int          cmp_count = 0;
    int          n_hard = 0;
    logic [7:0]  regs [8] = '{ADDR_CTRL, ADDR_MODE, ADDR_TON, ADDR_TOFF, ADDR_CURR, ADDR_STAT, ADDR_EFF1, 8'h40};
    logic [5:0]  seq_p [5] = '{6'h01, 6'h00, 6'h02, 6'h01, 6'h02};
    logic [11:0] seq_e [5] = '{12'h001, 12'h000, 12'h008, 12'h001, 12'h008};

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    hb_pwm_ctrl #(.ACT_CCP(2), .FW_CCP(4), .FW_TMO(8)) i_hb_pwm_ctrl (
        .CORE_CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF),
        .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .DRIVE_INPUT_I(pins), .ACTIVE_SENSE_I(sense), .MEAS_I(meas),
        .HIGH_SIDE_SWITCH_O(hs), .LOW_SIDE_SWITCH_O(ls), .ACTIVE_HOLD_OFF_O(hold),
        .HARD_OFF_CURRENT_O(hard), .GATE_CURRENT_O(gcur), .DELAY_REGULATION_FLAG_O(flag));
    hb_host_model i_hb_host_model (.clk_i(clk), .pat_i(pat), .lag_i(lag), .pins_o(pins));

    // ==========
    // Tasks
    task automatic cmp(input string what, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, x, g);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int k;
        if (!w)
            rd_q.push_back(v);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) begin
            cmp("ack", 32'h1, {31'h0, ack});
            end_of_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [11:0] x);
        sw_q.push_back(x);
        smp <= 1'b1;
        @(posedge clk);
        smp <= 1'b0;
        @(posedge clk);
    endtask
    task automatic step(input int b, input logic u, input logic [7:0] on, input logic [7:0] off);
        meas[b] <= '{1'b1, u, on, off};
        @(posedge clk);
        meas[b].strobe <= 1'b0;
        @(posedge clk);
    endtask

    // ==========
    // Monitor
    always @(posedge clk) begin
        if (ack === 1'b1 && !we && rd_q.size() > 0)
            cmp("read data", rd_q.pop_front(), rdat);
        if (smp && sw_q.size() > 0)
            cmp("bridges", {20'h0, sw_q.pop_front()}, {20'h0, flag, hold, ls, hs});
        if (hard[0] === 1'b1)
            n_hard++;
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    // ==========
    // Sequence
    initial begin
        d = $urandom(99);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wb(1'b1, ADDR_STAT, 32'hFFFF_FFFF);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        for (int i = 0; i < 8; i++)
            wb(1'b0, regs[i], 32'h0);
        chk(12'h000);
        d = $urandom();
        wb(1'b1, ADDR_CURR, d);
        wb(1'b0, ADDR_CURR, d & CURR_MSK);
        cmp("gate current", {14'h0, d[21:16], d[13:8], d[5:0]}, {14'h0, gcur});
        for (int n = 0; n < 30; n++) begin
            ctrl = ($urandom() & CTRL_MSK) | 32'(n % 4 != 0);
            mode = $urandom() & MODE_MSK;
            wb(1'b1, ADDR_CTRL, ctrl);
            wb(1'b1, ADDR_MODE, mode);
            pat <= 6'($urandom());
            sense <= 3'($urandom());
            lag <= 4'($urandom() % 4);
            repeat (24) @(posedge clk);
            e = 12'h000;
            t = 8'h00;
            for (int b = 0; b < 3; b++) begin
                e[6+b] = (mode[2*b+:2] == MODE_HOLD);
                t[b] = ctrl[1] ? sense[b] : (mode[2*b+:2] == MODE_HS_ACT);
                if (ctrl[0] && ctrl[8+b] && mode[2*b] != mode[2*b+1] && pat[2*b] != pat[2*b+1]) begin
                    e[b] = pat[2*b+mode[2*b]];
                    e[3+b] = !pat[2*b+mode[2*b]];
                end
            end
            chk(e);
            wb(1'b0, ADDR_STAT, {17'h0, e[5:3], 1'b0, e[2:0], 1'b0, t[2:0], 4'h0});
        end
        wb(1'b1, ADDR_CTRL, 32'h0000_0101);
        wb(1'b1, ADDR_MODE, {30'h0, MODE_HS_ACT});
        lag <= 4'h0;
        pat <= 6'h00;
        repeat (24) @(posedge clk);
        n_hard = 0;
        for (int i = 0; i < 5; i++) begin
            pat <= seq_p[i];
            repeat (24) @(posedge clk);
            chk(seq_e[i]);
        end
        cmp("hard off pulses", 32'h1, 32'(n_hard));
        d = ($urandom() & 32'h7E7E) | 32'h0101;
        wb(1'b1, ADDR_CTRL, 32'h0000_0021);
        wb(1'b1, ADDR_TON, d);
        wb(1'b1, ADDR_TOFF, d);
        for (int k = 0; k < 20; k++) begin
            step(0, 1'b0, d[7:0], d[7:0]);
            chk({2'b00, k >= 7, 9'h000});
        end
        for (int k = 0; k < 8; k++) begin
            step(0, 1'b0, d[7:0] + 8'h1, d[7:0] + 8'h1);
            chk({2'b00, k < 7, 9'h000});
        end
        for (int k = 0; k < 4; k++) begin
            t = k[0] ? d[15:8] - 8'h1 : d[15:8] + 8'h1;
            step(1, 1'b0, t, t);
            chk({1'b0, k == 3, 10'h000});
        end
        wb(1'b1, ADDR_CTRL, 32'h0000_0011);
        chk(12'h000);
        step(2, 1'b1, 8'h55, 8'h66);
        wb(1'b0, ADDR_EFF3, 32'h0);
        step(2, 1'b0, d[7:0], d[15:8]);
        wb(1'b0, ADDR_EFF3, {16'h0, d[15:8], d[7:0]});
        end_of_test();
    end
endmodule

bind hb_pwm_ctrl hb_pwm_ctrl_checker #(.ACT_CCP(ACT_CCP), .FW_CCP(FW_CCP), .FW_TMO(FW_TMO)) i_hb_pwm_ctrl_checker (
    .CORE_CLK_I, .RST_I, .CYC_I, .STB_I, .WE_I, .ACK_O, .MEAS_I, .HIGH_SIDE_SWITCH_O, .LOW_SIDE_SWITCH_O,
    .ACTIVE_HOLD_OFF_O, .HARD_OFF_CURRENT_O, .GATE_CURRENT_O, .DELAY_REGULATION_FLAG_O);
